/* logic/eeprom_lock_pkg.sv */
// Constants and region decode for the lockable EEPROM access block
`default_nettype none
package eeprom_lock_pkg;
    // Array shape
    localparam int ARRAY_DEPTH = 512;
    localparam int ADDR_W = 9;
    localparam int PAGE_BYTES = 16;
    localparam int PAGE_W = 4;
    // Instruction opcodes
    localparam logic [7:0] OPC_LATCH_SET = 8'h06;
    localparam logic [7:0] OPC_LATCH_CLEAR = 8'h04;
    localparam logic [7:0] OPC_ARRAY_WRITE = 8'h02;
    localparam logic [7:0] OPC_ARRAY_READ = 8'h03;
    localparam logic [7:0] OPC_LOCK_STATUS = 8'h05;
    localparam logic [7:0] OPC_PARTITION_LOCK = 8'h01;
    // Lock register layout and value after reset
    localparam int LOCK_SEL_W = 3;
    localparam logic [7:0] LOCK_RESET = 8'h00;
    localparam logic [7:0] BUSY_STATUS = 8'hff;
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Times in microseconds and their cycle counts at the core clock
    localparam int CLK_MHZ = 125;
    localparam int POWERUP_READ_WAIT_US = 1;
    localparam int POWERUP_WRITE_WAIT_US = 5;
    localparam int WRITE_CYCLE_US = 5;
    localparam logic [9:0] PU_READ_CYCLES =
        10'(POWERUP_READ_WAIT_US * CLK_MHZ);
    localparam logic [9:0] PU_WRITE_CYCLES =
        10'(POWERUP_WRITE_WAIT_US * CLK_MHZ);
    localparam logic [9:0] WRITE_CYCLES = 10'(WRITE_CYCLE_US * CLK_MHZ);

    // True when an address falls inside the selected locked region
    function automatic logic lock_hit(input logic [2:0] sel,
                                      input logic [8:0] addr);
        logic hit;
        hit = 1'b0;
        case (sel)
            3'h1: hit = (addr[8:7] == 2'h0);
            3'h2: hit = (addr[8:7] == 2'h1);
            3'h3: hit = (addr[8:7] == 2'h2);
            3'h4: hit = (addr[8:7] == 2'h3);
            3'h5: hit = (addr[8] == 1'b0);
            3'h6: hit = (addr[8:4] == 5'h00);
            3'h7: hit = (addr[8:4] == 5'h1f);
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : lock_hit
endpackage : eeprom_lock_pkg
`default_nettype wire

/* logic/spi_events_if.sv */
// Sampled serial-port events passed from the pin sampler to the core
`timescale 1ns/1ns
`default_nettype none
interface spi_events_if;
    logic selected;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic si_bit;
    modport sampler (output selected, cs_rise, sck_rise, sck_fall, si_bit);
    modport core (input selected, cs_rise, sck_rise, sck_fall, si_bit);
endinterface : spi_events_if
`default_nettype wire

/* logic/spi_pin_sampler.sv */
// Three-stage pin sampler with edge detection for the serial port
`timescale 1ns/1ns
`default_nettype none
module spi_pin_sampler (
    input wire logic clock, // Core clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic cs_n, // Chip select pin, active low
    input wire logic sck, // Serial clock pin
    input wire logic si, // Serial data in pin
    spi_events_if.sampler ev // Sampled events
);
    logic [2:0] s1_reg, s2_reg, s3_reg;
    logic [2:0] level_reg; // {cs_n, sck, si} after filtering
    logic [2:0] prev_reg;

    // Three flops per pin; first stage feeds only the second
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            // Idle levels {cs_n high, sck low, si high}; no false edge
            s1_reg <= 3'h5;
            s2_reg <= 3'h5;
            s3_reg <= 3'h5;
        end else begin
            s1_reg <= {cs_n, sck, si};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change counts only once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_filter
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    level_reg[g] <= (g != 1);
                    prev_reg[g] <= (g != 1);
                end else begin
                    if (s2_reg[g] == s3_reg[g])
                        level_reg[g] <= s3_reg[g];
                    prev_reg[g] <= level_reg[g];
                end
            end
        end
    endgenerate

    // Clock edges gated by select so stray clocks while idle are ignored
    assign ev.selected = !level_reg[2];
    assign ev.cs_rise = level_reg[2] && !prev_reg[2];
    assign ev.sck_rise = !level_reg[2] && level_reg[1] && !prev_reg[1];
    assign ev.sck_fall = !level_reg[2] && !level_reg[1] && prev_reg[1];
    assign ev.si_bit = level_reg[0];
endmodule : spi_pin_sampler
`default_nettype wire

/* logic/eeprom_partition_lock_access.sv */
// Serial EEPROM core with write-enable latch and partition lock
// Operation
// - Array holds 512 bytes reached through the serial port.
// - Array accesses served except during sleep or a write cycle.
// - Reads and writes refused until their power-up waits elapse.
// - Array writes happen only with the write-enable latch set.
// - Latch-set opcode sets the latch, latch-clear opcode clears it.
// - Latch clears at power-up and after each write cycle.
// - Seven lockable regions, from one page up to half the array.
// - Lock sequence is honoured only while the latch is set.
// - Three lock bits select none or one of seven fixed ranges.
// - Deselect after the lock sequence writes the lock register.
// - Later protection bytes replace earlier ones; last kept.
// - Lock setting held until another lock sequence completes; reset clears it to 00 here.
// - Locked ranges readable but writes to them refused.
// - Lock register bits seven to three always read zero; status reads during a write cycle return ff.
// - Opcode 06 sets the write-enable latch.
// - Opcode 04 clears the write-enable latch.
// - Opcode 01 is the lock opcode followed by the partition byte.
// - Latch-set must end with deselect, else the write is ignored.
`timescale 1ns/1ns
`default_nettype none
module eeprom_partition_lock_access (
    input wire logic clock, // Core clock, 125 MHz
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic cs_n, // Chip select pin, active low
    input wire logic sck, // Serial clock pin, mode 0
    input wire logic si, // Serial data in
    input wire logic sleep_mode, // Device sleep, refuses array access
    output logic so_out, // Serial data out
    output logic so_oe, // Serial out enable, high while driving
    output logic [eeprom_lock_pkg::LOCK_SEL_W-1:0] lock_region_sel, // Lock
    output logic write_busy, // Nonvolatile write cycle running
    output logic latch_set // Write-enable latch state
);
    import eeprom_lock_pkg::*;

    typedef enum {ST_IDLE, ST_OPCODE, ST_ADDR, ST_WDATA, ST_RDATA, ST_STAT,
                  ST_LOCK, ST_LATCH, ST_IGNORE} state_e;

    spi_events_if ev ();

    spi_pin_sampler u_sampler (
        .clock(clock),
        .rst_n(rst_n),
        .cs_n(cs_n),
        .sck(sck),
        .si(si),
        .ev(ev)
    );

    state_e state_reg;
    logic [2:0] bit_cnt_reg;
    logic addr_byte_reg;
    logic is_write_reg;
    logic [7:0] shift_reg, tx_reg, lock_reg, lock_pend_reg;
    logic lock_got_reg, so_reg, wel_reg, busy_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [9:0] busy_cnt_reg, pu_cnt_reg;
    logic [7:0] mem [ARRAY_DEPTH];
    logic [7:0] page_reg [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_vld_reg;
    logic [7:0] rx_byte;
    logic byte_done, busy_done, read_ok, write_ok;
    logic commit, commit_any, lock_commit, latch_commit;

    // Byte assembly; the last bit arrives with the completing edge
    assign rx_byte = {shift_reg[6:0], ev.si_bit};
    assign byte_done = ev.sck_rise && (bit_cnt_reg == BIT_LAST);
    assign busy_done = busy_reg && (busy_cnt_reg == 10'h001);
    assign read_ok = (pu_cnt_reg >= PU_READ_CYCLES);
    assign write_ok = (pu_cnt_reg >= PU_WRITE_CYCLES);
    // Deselect only counts on a byte boundary
    assign latch_commit = ev.cs_rise && state_reg == ST_LATCH &&
                          bit_cnt_reg == 3'h0;
    assign lock_commit = ev.cs_rise && state_reg == ST_LOCK &&
                         lock_got_reg && bit_cnt_reg == 3'h0;
    assign commit = ev.cs_rise && state_reg == ST_WDATA &&
                    bit_cnt_reg == 3'h0 && |page_vld_reg;

    // Any buffered byte that lands outside the locked region
    always_comb begin
        commit_any = 1'b0;
        for (int i = 0; i < PAGE_BYTES; i++) begin
            if (page_vld_reg[i] && !lock_hit(lock_reg[2:0],
                {addr_reg[8:4], PAGE_W'(i)}))
                commit_any = 1'b1;
        end
    end

    // Bit counter and receive shifter
    always_ff @(posedge clock) begin
        if (!rst_n || !ev.selected) begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
        end else if (ev.sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= rx_byte;
        end
    end

    // Command sequencer, stepped at each completed byte
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            addr_byte_reg <= 1'b0;
            is_write_reg <= 1'b0;
        end else if (!ev.selected) begin
            state_reg <= ST_IDLE;
            addr_byte_reg <= 1'b0;
        end else if (state_reg == ST_IDLE) begin
            state_reg <= ST_OPCODE;
        end else if (state_reg == ST_LATCH && ev.sck_rise) begin
            state_reg <= ST_IGNORE;
        end else if (byte_done) begin
            case (state_reg)
                ST_OPCODE: begin
                    state_reg <= ST_IGNORE;
                    if (rx_byte == OPC_LATCH_SET)
                        state_reg <= ST_LATCH;
                    else if (rx_byte == OPC_ARRAY_WRITE && wel_reg &&
                             write_ok && !busy_reg && !sleep_mode) begin
                        state_reg <= ST_ADDR;
                        is_write_reg <= 1'b1;
                    end else if (rx_byte == OPC_ARRAY_READ && read_ok &&
                                 !busy_reg && !sleep_mode) begin
                        state_reg <= ST_ADDR;
                        is_write_reg <= 1'b0;
                    end else if (rx_byte == OPC_LOCK_STATUS)
                        state_reg <= ST_STAT;
                    else if (rx_byte == OPC_PARTITION_LOCK && wel_reg &&
                             !busy_reg)
                        state_reg <= ST_LOCK;
                end
                ST_ADDR: begin
                    addr_byte_reg <= 1'b1;
                    if (addr_byte_reg)
                        state_reg <= is_write_reg ? ST_WDATA : ST_RDATA;
                end
                default: state_reg <= state_reg;
            endcase
        end
    end

    // Address counter: page wrap on writes, full wrap on reads
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr_reg <= '0;
        end else if (byte_done && state_reg == ST_ADDR) begin
            if (!addr_byte_reg)
                addr_reg[8] <= rx_byte[0];
            else
                addr_reg[7:0] <= rx_byte;
        end else if (byte_done && state_reg == ST_WDATA) begin
            addr_reg[3:0] <= addr_reg[3:0] + 4'h1;
        end else if (byte_done && state_reg == ST_RDATA) begin
            addr_reg <= addr_reg + 9'h001;
        end
    end

    // Page buffer; bytes reach the array only on a clean deselect
    always_ff @(posedge clock) begin
        if (!rst_n || state_reg == ST_IDLE) begin
            page_vld_reg <= '0;
        end else if (byte_done && state_reg == ST_WDATA) begin
            page_reg[addr_reg[3:0]] <= rx_byte;
            page_vld_reg[addr_reg[3:0]] <= 1'b1;
        end
    end

    // Array store; locked bytes are dropped silently
    always_ff @(posedge clock) begin
        if (commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (page_vld_reg[i] && !lock_hit(lock_reg[2:0],
                    {addr_reg[8:4], PAGE_W'(i)}))
                    mem[{addr_reg[8:4], PAGE_W'(i)}] <= page_reg[i];
            end
        end
    end

    // Protection byte capture; the newest byte replaces older ones
    always_ff @(posedge clock) begin
        if (!rst_n || state_reg == ST_IDLE) begin
            lock_pend_reg <= 8'h00;
            lock_got_reg <= 1'b0;
        end else if (byte_done && state_reg == ST_LOCK) begin
            lock_pend_reg <= rx_byte;
            lock_got_reg <= 1'b1;
        end
    end

    // Lock register; stands in for the nonvolatile cell
    always_ff @(posedge clock) begin
        if (!rst_n)
            lock_reg <= LOCK_RESET;
        else if (lock_commit)
            lock_reg <= {5'h00, lock_pend_reg[2:0]};
    end

    // Nonvolatile write cycle timer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            busy_cnt_reg <= 10'h000;
        end else if ((commit && commit_any) || lock_commit) begin
            busy_reg <= 1'b1;
            busy_cnt_reg <= WRITE_CYCLES;
        end else if (busy_reg) begin
            busy_cnt_reg <= busy_cnt_reg - 10'h001;
            if (busy_done)
                busy_reg <= 1'b0;
        end
    end

    // Power-up wait counter, saturates at the longer wait
    always_ff @(posedge clock) begin
        if (!rst_n)
            pu_cnt_reg <= 10'h000;
        else if (!write_ok)
            pu_cnt_reg <= pu_cnt_reg + 10'h001;
    end

    // Write-enable latch; clear at reset and at end of every write cycle
    always_ff @(posedge clock) begin
        if (!rst_n)
            wel_reg <= 1'b0;
        else if (busy_done)
            wel_reg <= 1'b0;
        else if (latch_commit)
            wel_reg <= 1'b1;
        else if (byte_done && state_reg == ST_OPCODE &&
                 rx_byte == OPC_LATCH_CLEAR)
            wel_reg <= 1'b0;
    end

    // Transmit shifter: load on rising edge, shift out on falling edge
    always_ff @(posedge clock) begin
        if (!rst_n || !ev.selected) begin
            tx_reg <= 8'h00;
            so_reg <= 1'b0;
        end else if (byte_done && state_reg == ST_OPCODE &&
                     rx_byte == OPC_LOCK_STATUS) begin
            tx_reg <= busy_reg ? BUSY_STATUS : lock_reg;
        end else if (byte_done && state_reg == ST_STAT) begin
            tx_reg <= busy_reg ? BUSY_STATUS : lock_reg;
        end else if (byte_done && state_reg == ST_ADDR && addr_byte_reg &&
                     !is_write_reg) begin
            tx_reg <= mem[{addr_reg[8], rx_byte}];
        end else if (byte_done && state_reg == ST_RDATA) begin
            tx_reg <= mem[addr_reg + 9'h001];
        end else if (ev.sck_fall && (state_reg == ST_RDATA ||
                                     state_reg == ST_STAT)) begin
            so_reg <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
        end
    end

    assign so_out = so_reg;
    assign so_oe = ev.selected && (state_reg == ST_RDATA ||
                                   state_reg == ST_STAT);
    assign lock_region_sel = lock_reg[2:0];
    assign write_busy = busy_reg;
    assign latch_set = wel_reg;

    // Checks
    sequence seq_lock_seen;
        lock_commit ##1 busy_reg;
    endsequence

    a_wel_set_cmd: assert property (@(posedge clock)
        disable iff (!rst_n) latch_commit && !busy_done |=> wel_reg)
        else $error("latch not set after latch-set sequence");
    a_wel_auto_clear: assert property (@(posedge clock)
        disable iff (!rst_n) busy_done |=> !wel_reg && !busy_reg)
        else $error("latch not cleared after write cycle");
    a_wel_clear_cmd: assert property (@(posedge clock)
        disable iff (!rst_n)
        byte_done && state_reg == ST_OPCODE && rx_byte == 8'h04
        |=> !wel_reg)
        else $error("latch-clear opcode ignored");
    a_write_needs_wel: assert property (@(posedge clock)
        disable iff (!rst_n)
        state_reg == ST_WDATA |-> wel_reg && write_ok)
        else $error("array write accepted without latch");
    a_lock_needs_wel: assert property (@(posedge clock)
        disable iff (!rst_n)
        byte_done && state_reg == ST_OPCODE && rx_byte == 8'h01 && !wel_reg
        |=> state_reg == ST_IGNORE)
        else $error("lock accepted without latch");
    a_lock_update: assert property (@(posedge clock)
        disable iff (!rst_n)
        seq_lock_seen |-> lock_reg == {5'h00, $past(lock_pend_reg[2:0], 1)})
        else $error("lock register not written");
    a_lock_high_zero: assert property (@(posedge clock)
        disable iff (!rst_n) lock_reg[7:3] == 5'h00)
        else $error("lock register upper bits set");
    a_locked_no_cycle: assert property (@(posedge clock)
        disable iff (!rst_n) commit && !commit_any |=> !busy_reg)
        else $error("write cycle started for locked bytes");
    a_sleep_refuse: assert property (@(posedge clock)
        disable iff (!rst_n)
        byte_done && state_reg == ST_OPCODE && sleep_mode &&
        (rx_byte == 8'h02 || rx_byte == 8'h03) |=> state_reg == ST_IGNORE)
        else $error("array access served in sleep");
    a_pu_read_wait: assert property (@(posedge clock)
        disable iff (!rst_n) state_reg == ST_ADDR |-> read_ok)
        else $error("array access before power-up wait");
    a_latch_tail: assert property (@(posedge clock)
        disable iff (!rst_n)
        state_reg == ST_LATCH && ev.selected && ev.sck_rise
        |=> state_reg == ST_IGNORE [*2])
        else $error("latch-set not terminated by deselect");
endmodule : eeprom_partition_lock_access
`default_nettype wire

/* sim/spi_host_model.sv */
// Serial-port master model standing in for the host microcontroller
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    output logic cs_n, // Chip select, active low
    output logic sck, // Serial clock, mode 0
    output logic si, // Serial data towards the device
    input wire logic so_out, // Serial data from the device
    input wire logic so_oe // High while the device drives so_out
);
    logic oe_seen; // Device output enable seen in this frame

    // Idle link: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        oe_seen = 1'b0;
    end

    // Remember any drive of the output line during a frame
    always @(posedge so_oe) oe_seen = 1'b1;

    // Select the device, clock still low
    task automatic open_frame();
        cs_n = 1'b0;
        oe_seen = 1'b0;
        #100;
    endtask : open_frame

    // One byte MSB first; data set while low, reply taken at the rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            #62;
            sck = 1'b1;
            rx[i] = so_out;
            #63;
            sck = 1'b0;
        end
    endtask : xfer

    // Deselect only after bit 0, then scramble the released data line
    task automatic close_frame();
        #63;
        cs_n = 1'b1;
        si = ~si; // Stale value would hide a missed sample
        #200;
    endtask : close_frame
endmodule : spi_host_model
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the lockable EEPROM access block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import eeprom_lock_pkg::*;
    logic clock;
    logic rst_n;
    logic sleep_mode;
    wire logic cs_n;
    wire logic sck;
    wire logic si;
    logic so_out;
    logic so_oe;
    logic [LOCK_SEL_W-1:0] lock_region_sel;
    logic write_busy;
    logic latch_set;
    int fail_count = 0;
    int checks = 0;
    logic [7:0] exp_q[$];
    logic [7:0] seen_val;
    event seen_ev;
    logic [7:0] mem_m [ARRAY_DEPTH];
    logic [2:0] sel_m;
    logic [7:0] rx;
    logic [8:0] probe [4] = '{9'h00f, 9'h010, 9'h100, 9'h1f0};

    eeprom_partition_lock_access u_dut (.clock(clock), .rst_n(rst_n),
        .cs_n(cs_n), .sck(sck), .si(si), .sleep_mode(sleep_mode),
        .so_out(so_out), .so_oe(so_oe), .lock_region_sel(lock_region_sel),
        .write_busy(write_busy), .latch_set(latch_set));
    spi_host_model u_host (.cs_n(cs_n), .sck(sck), .si(si),
        .so_out(so_out), .so_oe(so_oe));

    // Core clock, 8 ns period
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Scoreboard: oldest note against each result shown
    initial begin
        forever begin
            @(seen_ev);
            check(seen_val, exp_q.pop_front());
        end
    end

    // Note the expectation, then show the result to the scoreboard
    task automatic note(input logic [7:0] seen, input logic [7:0] exp);
        exp_q.push_back(exp);
        seen_val = seen;
        -> seen_ev;
        #1;
    endtask : note

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // Reference decode written as plain address ranges
    function automatic bit locked(input logic [2:0] s, input logic [8:0] a);
        case (s)
            3'h1: return a <= 9'h07f;
            3'h2: return a >= 9'h080 && a <= 9'h0ff;
            3'h3: return a >= 9'h100 && a <= 9'h17f;
            3'h4: return a >= 9'h180;
            3'h5: return a <= 9'h0ff;
            3'h6: return a <= 9'h00f;
            3'h7: return a >= 9'h1f0;
            default: return 1'b0;
        endcase
    endfunction : locked

    task automatic clocks(input int n);
        repeat (n) @(negedge clock);
    endtask : clocks

    task automatic cmd(input logic [7:0] opc);
        u_host.open_frame();
        u_host.xfer(opc, rx);
        u_host.close_frame();
    endtask : cmd

    // Bounded wait for the write cycle to end
    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < 1000) begin
            @(negedge clock);
            n++;
        end
        note({7'h00, write_busy}, 8'h00);
    endtask : wait_idle

    // Page write of n random bytes; ok says whether a commit is due
    task automatic wr(input logic [8:0] a, input int n, input bit arm,
                      input bit ok);
        logic [7:0] d;
        logic [8:0] slot;
        bit any;
        any = 1'b0;
        if (arm) cmd(OPC_LATCH_SET);
        u_host.open_frame();
        u_host.xfer(OPC_ARRAY_WRITE, rx);
        u_host.xfer({7'h00, a[8]}, rx);
        u_host.xfer(a[7:0], rx);
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            slot = {a[8:4], a[3:0] + 4'(k)}; // Wraps inside the page
            u_host.xfer(d, rx);
            if (ok && !locked(sel_m, slot)) begin
                mem_m[slot] = d;
                any = 1'b1;
            end
        end
        u_host.close_frame();
        clocks(12);
        note({7'h00, write_busy}, {7'h00, any});
        if (any) begin
            wait_idle();
            note({7'h00, latch_set}, 8'h00);
        end
    endtask : wr

    // Sequential read; data compared only when the device may answer
    task automatic rd(input logic [8:0] a, input int n, input bit oe_exp);
        u_host.open_frame();
        u_host.xfer(OPC_ARRAY_READ, rx);
        u_host.xfer({7'h00, a[8]}, rx);
        u_host.xfer(a[7:0], rx);
        for (int k = 0; k < n; k++) begin
            u_host.xfer(8'($urandom), rx);
            if (oe_exp) note(rx, mem_m[a + 9'(k)]);
        end
        u_host.close_frame();
        note({7'h00, u_host.oe_seen}, {7'h00, oe_exp});
    endtask : rd

    // Lock sequence with a spare first byte that the last must replace
    task automatic lock(input logic [2:0] sel, input bit arm);
        if (arm) cmd(OPC_LATCH_SET);
        u_host.open_frame();
        u_host.xfer(OPC_PARTITION_LOCK, rx);
        u_host.xfer({5'h00, 3'($urandom)}, rx);
        u_host.xfer({5'h00, sel}, rx);
        u_host.close_frame();
        if (arm) sel_m = sel;
        clocks(12);
        note({5'h00, lock_region_sel}, {5'h00, sel_m});
        note({7'h00, write_busy}, {7'h00, arm});
        wait_idle();
        note({7'h00, latch_set}, 8'h00);
    endtask : lock

    // Watchdog: the sequence needs about 0.6 ms; stay under 100k cycles
    initial begin
        #700000;
        fail_count++;
        stop_test();
    end

    initial begin
        rst_n = 1'b0;
        sleep_mode = 1'b0;
        sel_m = 3'h0;
        void'($urandom(32'h8f6f));
        clocks(3);
        rst_n = 1'b1;
        note({7'h00, latch_set}, 8'h00);
        note({5'h00, lock_region_sel}, 8'h00);
        note({7'h00, write_busy}, 8'h00);
        $display("test reset done");
        clocks(6);
        wr(9'h020, 1, 1'b1, 1'b0);
        note({7'h00, latch_set}, 8'h01);
        clocks(700);
        cmd(OPC_LATCH_CLEAR);
        clocks(8);
        note({7'h00, latch_set}, 8'h00);
        wr(9'h020, 1, 1'b0, 1'b0);
        // Latch-set not closed by deselect voids the following write
        u_host.open_frame();
        u_host.xfer(OPC_LATCH_SET, rx);
        u_host.xfer(OPC_ARRAY_WRITE, rx);
        u_host.xfer(8'h00, rx);
        u_host.xfer(8'h20, rx);
        u_host.xfer(8'h55, rx);
        u_host.close_frame();
        clocks(12);
        note({7'h00, write_busy}, 8'h00);
        note({7'h00, latch_set}, 8'h00);
        $display("test refusals done");
        wr(9'h1fe, 3, 1'b1, 1'b1);
        wr(9'h000, 1, 1'b1, 1'b1);
        rd(9'h1fe, 3, 1'b1);
        @(negedge clock) sleep_mode = 1'b1;
        rd(9'h1fe, 1, 1'b0);
        wr(9'h000, 1, 1'b1, 1'b0);
        @(negedge clock) sleep_mode = 1'b0;
        $display("test array and sleep done");
        for (int s = 0; s < 8; s++) begin
            lock(3'(s), 1'b1);
            u_host.open_frame();
            u_host.xfer(OPC_LOCK_STATUS, rx);
            u_host.xfer(8'h00, rx);
            note(rx, {5'h00, sel_m});
            u_host.close_frame();
            for (int i = 0; i < 4; i++) begin
                wr(probe[i], 1, 1'b1, 1'b1);
                rd(probe[i], 1, 1'b1);
            end
            $display("test lock code %0d done", s);
        end
        cmd(OPC_LATCH_CLEAR);
        lock(3'h2, 1'b0);
        $display("test unarmed lock done");
        stop_test();
    end
endmodule : tb
`default_nettype wire
